// ===== rtl/gdts_pkg.sv
// Shared constants, modes and carrier types of the geared DDR transmit serializer.
package gdts_pkg;

  // ----------------------------------------------------------------------------
  // Widths and lane count
  // ----------------------------------------------------------------------------
  localparam int LANES = 4;              // Data lanes driven from one shared gearing.
  localparam int WORD_W = 7;             // Widest parallel word (seven-to-one mode).
  localparam int BUF_W = 8;              // Leftover bits plus one fresh word fit here.
  localparam int CNT_W = 4;              // Width of the fill counter.
  localparam int WIDE_W = 2 * BUF_W;     // Scratch width while merging a fresh word.
  localparam int TIMER_W = 8;            // Width of the startup phase timer.

  // ----------------------------------------------------------------------------
  // Gearing figures
  // ----------------------------------------------------------------------------
  localparam logic [CNT_W-1:0] BITS_7TO1 = 4'h7;   // Bits per word, seven-to-one.
  localparam logic [CNT_W-1:0] BITS_4TO1 = 4'h4;   // Bits per word, four-to-one.
  localparam logic [CNT_W-1:0] BITS_1TO1 = 4'h1;   // Bits per word, one-to-one.
  localparam logic [CNT_W-1:0] BITS_PER_EDGE = 4'h2; // Bits sent per fast cycle (both edges).
  localparam logic [CNT_W-1:0] FILL_EMPTY = 4'h0;  // Fill value after reset.

  // Forwarded clock patterns, sent least significant bit first.
  localparam logic [WORD_W-1:0] CLK_PAT_7TO1 = 7'h63;  // Two high, three low, two high.
  localparam logic [WORD_W-1:0] CLK_PAT_4TO1 = 7'h05;  // One, zero, one, zero.
  localparam logic CLK_RISE_1TO1 = 1'h1;                // Plain clock in one-to-one mode.
  localparam logic CLK_FALL_1TO1 = 1'h0;

  // ----------------------------------------------------------------------------
  // Startup timing
  // ----------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;     // Core clock at 50 MHz.
  localparam int SETTLE_NS = 60;         // Least hold time of each startup phase.
  localparam logic [TIMER_W-1:0] SETTLE_CYC =
    TIMER_W'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 8'h00;
  localparam logic [TIMER_W-1:0] TIMER_STEP = 8'h01;

  // ----------------------------------------------------------------------------
  // Modes, states and carriers
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_7TO1 = 2'b00,                   // Display-style LVDS, aligned clock.
    MODE_4TO1 = 2'b01,                   // D-PHY style, centred clock.
    MODE_1TO1 = 2'b10                    // Primary clock only, no divider.
  } gdts_mode_e;

  typedef enum logic [2:0] {
    ST_WAIT_LOCK = 3'b000,               // Waiting for a locked fast clock source.
    ST_STOP = 3'b001,                    // Edge clock stopped before reset.
    ST_RESET = 3'b010,                   // Divider and serializers in reset.
    ST_RELEASE = 3'b011,                 // Reset released, clock still stopped.
    ST_READY = 3'b100                    // Streaming.
  } gdts_state_e;

  typedef logic [WORD_W-1:0] gdts_word_t;

  typedef struct packed {
    gdts_mode_e mode;                    // Gearing ratio.
    logic stop_en;                       // Clock alignment by stop is enabled.
    logic centred;                       // Clock lane on its own shifted edge clock, in four-to-one mode only.
  } gdts_cfg_s;

  typedef struct packed {
    logic fall;                          // Bit sent on the falling fast edge.
    logic rise;                          // Bit sent on the rising fast edge.
  } gdts_pair_s;

endpackage : gdts_pkg

// ===== rtl/gdts_edge_clock_divider.sv
// Shared edge clock divider: paces word loads for all serializer lanes.
`timescale 1ns/10ps
`default_nettype none
module gdts_edge_clock_divider (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic ratio_one_i,
  input wire logic [gdts_pkg::CNT_W-1:0] bits_per_word_i,
  output logic take_o,
  output logic take_next_o,
  output logic [gdts_pkg::CNT_W-1:0] fill_o
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [gdts_pkg::CNT_W-1:0] fill;    // Bits still waiting in every lane buffer.
  } gdts_div_state_s;

  gdts_div_state_s state_reg;
  gdts_div_state_s state_next;

  // A word is loaded whenever fewer bits remain than one fast cycle sends.
  // In one-to-one mode the divider is bypassed and a word is taken each cycle.
  assign take_o = run_i & (ratio_one_i | (state_reg.fill < gdts_pkg::BITS_PER_EDGE));
  assign fill_o = state_reg.fill;
  assign take_next_o = ratio_one_i | (state_next.fill < gdts_pkg::BITS_PER_EDGE);

  // Next fill: add a word when taken, drain two bits every fast cycle.
  always_comb begin
    state_next = state_reg;
    if (!run_i || ratio_one_i) begin
      // Held empty out of streaming so the word boundary restarts cleanly.
      state_next.fill = gdts_pkg::FILL_EMPTY;
    end else if (take_o) begin
      state_next.fill = state_reg.fill + bits_per_word_i - gdts_pkg::BITS_PER_EDGE;
    end else begin
      state_next.fill = state_reg.fill - gdts_pkg::BITS_PER_EDGE;
    end
  end

  // Register the divider state.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : gdts_edge_clock_divider
`default_nettype wire

// ===== rtl/gdts_serializer_top.sv
// Geared DDR transmit serializer: startup sequencing, shared divider and lane serializers.
`timescale 1ns/10ps
`default_nettype none
module gdts_serializer_top (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire gdts_pkg::gdts_cfg_s cfg_i,
  input wire logic lock_i,
  input wire gdts_pkg::gdts_word_t [gdts_pkg::LANES-1:0] word_i,
  output gdts_pkg::gdts_pair_s [gdts_pkg::LANES-1:0] lane_o,
  output gdts_pkg::gdts_pair_s clk_lane_o,
  output logic word_take_o,
  output logic edge_stop_o,
  output logic sync_reset_o,
  output logic clk_shift_en_o,
  output logic ready_o
);

  // ----------------------------------------------------------------------------
  // State of the whole block
  // ----------------------------------------------------------------------------
  // One record holds every flip-flop but the divider's, so reset
  // and clocking are written once for all.
  typedef struct packed {
    gdts_pkg::gdts_state_e fsm;                           // Startup sequencer state.
    logic [gdts_pkg::TIMER_W-1:0] timer;                  // Cycles spent in the phase.
    logic [gdts_pkg::LANES-1:0][gdts_pkg::BUF_W-1:0] bufs; // Leftover bits per data lane.
    logic [gdts_pkg::BUF_W-1:0] clk_buf;                  // Leftover bits of the clock lane.
    gdts_pkg::gdts_pair_s [gdts_pkg::LANES-1:0] lanes;    // Registered data edge pairs.
    gdts_pkg::gdts_pair_s clk_pair;                       // Registered clock edge pair.
    logic take;                                           // Word is sampled at next edge.
    logic stop;                                           // Edge clock stop request.
    logic sreset;                                         // Divider and serializer reset.
    logic shift_en;                                       // Clock lane uses shifted edge clock.
    logic ready;                                          // Transmitter may send.
  } gdts_top_state_s;

  gdts_top_state_s state_reg;
  gdts_top_state_s state_next;

  // Divider handshake wires.
  logic run;                                              // Streaming in this cycle.
  logic ratio_one;                                        // One-to-one gearing selected.
  logic [gdts_pkg::CNT_W-1:0] bits_per_word;              // Word size of the current mode.
  gdts_pkg::gdts_word_t clk_pattern;                      // Clock lane word of the mode.
  logic div_take;                                         // Load a word this cycle.
  logic div_take_next;                                    // Load a word next cycle.
  logic [gdts_pkg::CNT_W-1:0] div_fill;                   // Bits left in every buffer.
  gdts_pkg::gdts_word_t word_mask; // Live bits of a word in this mode.

  // ----------------------------------------------------------------------------
  // Merge one lane: add a fresh word above the leftovers, send the two lowest
  // ----------------------------------------------------------------------------
  // Returns {next buffer, fall bit, rise bit}. The same merge serves the data
  // lanes and the clock lane, which is what keeps the two in step.
  // The buffer holds at most one word plus one
  // leftover bit, so the scratch never overflows.
  function automatic logic [gdts_pkg::BUF_W+1:0] gdts_shift_step(
    input logic [gdts_pkg::BUF_W-1:0] buf_v,
    input gdts_pkg::gdts_word_t word,
    input logic [gdts_pkg::CNT_W-1:0] fill,
    input logic take,
    input logic one
  );
    logic [gdts_pkg::WIDE_W-1:0] wide;

    // Start from the leftovers alone.
    wide = gdts_pkg::WIDE_W'(buf_v);
    if (take) begin
      wide = wide | (gdts_pkg::WIDE_W'(word) << fill);
    end
    if (one) begin
      wide = {{(gdts_pkg::WIDE_W-2){1'b0}}, word[0], word[0]};
    end
    // Two low bits leave, the rest is kept.
    return wide[gdts_pkg::BUF_W+1:0];
  endfunction

  // ----------------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------------
  // Word size and clock lane pattern follow the gearing ratio.
  // Defaults keep the decode free of latches.
  always_comb begin
    bits_per_word = gdts_pkg::BITS_7TO1;
    clk_pattern = gdts_pkg::CLK_PAT_7TO1;
    ratio_one = 1'b0;
    case (cfg_i.mode)
      gdts_pkg::MODE_7TO1: begin
        bits_per_word = gdts_pkg::BITS_7TO1;
        clk_pattern = gdts_pkg::CLK_PAT_7TO1;
      end

      gdts_pkg::MODE_4TO1: begin
        bits_per_word = gdts_pkg::BITS_4TO1;
        // Clock lane toggles every bit.
        clk_pattern = gdts_pkg::CLK_PAT_4TO1;
      end

      gdts_pkg::MODE_1TO1: begin
        bits_per_word = gdts_pkg::BITS_1TO1;
        ratio_one = 1'b1;
      end

      default: begin
        // Unused code falls back to seven-to-one rather than stalling the link.
        bits_per_word = gdts_pkg::BITS_7TO1;
      end
    endcase
  end

  // Streaming once startup has finished.
  assign run = (state_reg.fsm == gdts_pkg::ST_READY);

  // Fresh words are ORed onto leftovers, so
  // bits above the word size must be cleared.
  assign word_mask = ~(gdts_pkg::gdts_word_t'('1) << bits_per_word);

  // ----------------------------------------------------------------------------
  // Shared divider
  // ----------------------------------------------------------------------------
  // All lanes follow this single fill count,
  // which keeps their word boundaries together.
  // slow pace from fast clock
  gdts_edge_clock_divider u_divider (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .run_i(run),
    .ratio_one_i(ratio_one),
    .bits_per_word_i(bits_per_word),
    .take_o(div_take),
    .take_next_o(div_take_next),
    .fill_o(div_fill)
  );

  // ----------------------------------------------------------------------------
  // Next state: startup sequencer and serializers
  // ----------------------------------------------------------------------------
  // The timer restarts at each phase change,
  // so a phase lasts the settle count plus one.
  always_comb begin
    logic [gdts_pkg::BUF_W+1:0] step;
    step = '0;
    // Hold every field unless told otherwise.
    state_next = state_reg;
    state_next.timer = state_reg.timer + gdts_pkg::TIMER_STEP;

    case (state_reg.fsm)
      gdts_pkg::ST_WAIT_LOCK: begin
        // Nothing moves until the fast clock source has locked.
        state_next.timer = gdts_pkg::TIMER_ZERO;
        if (lock_i) begin
          state_next.fsm = gdts_pkg::ST_STOP;
        end
      end

      gdts_pkg::ST_STOP: begin
        // Clock is stopped first so the reset edge lands on a quiet tree.
        if (state_reg.timer >= gdts_pkg::SETTLE_CYC) begin
          // Settled: move on to reset.
          state_next.fsm = gdts_pkg::ST_RESET;
          state_next.timer = gdts_pkg::TIMER_ZERO;
        end
      end

      gdts_pkg::ST_RESET: begin
        // Divider and serializers held in reset.
        if (state_reg.timer >= gdts_pkg::SETTLE_CYC) begin
          state_next.fsm = gdts_pkg::ST_RELEASE;
          state_next.timer = gdts_pkg::TIMER_ZERO;
        end
      end

      gdts_pkg::ST_RELEASE: begin
        // Reset is gone everywhere before the clock restarts, so skew between
        // the two cannot shift the word boundary of one lane against another.
        if (state_reg.timer >= gdts_pkg::SETTLE_CYC) begin
          state_next.fsm = gdts_pkg::ST_READY;
          state_next.timer = gdts_pkg::TIMER_ZERO;
        end
      end

      gdts_pkg::ST_READY: begin
        // Streaming; the timer rests at zero.
        state_next.timer = gdts_pkg::TIMER_ZERO;
      end

      default: begin
        // Illegal codes restart the sequence.
        state_next.fsm = gdts_pkg::ST_WAIT_LOCK;
        state_next.timer = gdts_pkg::TIMER_ZERO;
      end
    endcase

    // Losing lock restarts the whole sequence; a stale boundary is worse than a gap.
    if (!lock_i) begin
      state_next.fsm = gdts_pkg::ST_WAIT_LOCK;
      state_next.timer = gdts_pkg::TIMER_ZERO;
    end

    // Stop covers stop, reset and release.
    // stop only when enabled
    state_next.stop = cfg_i.stop_en &&
                      ((state_next.fsm == gdts_pkg::ST_STOP) ||
                       (state_next.fsm == gdts_pkg::ST_RESET) ||
                       (state_next.fsm == gdts_pkg::ST_RELEASE));
    // Reset is held only in its own phase.
    state_next.sreset = (state_next.fsm == gdts_pkg::ST_RESET);
    state_next.ready = (state_next.fsm == gdts_pkg::ST_READY);

    // aligned uses one clock
    // The shifted clock itself is made outside.
    state_next.shift_en = cfg_i.centred && (cfg_i.mode == gdts_pkg::MODE_4TO1);

    // Tell the source one cycle ahead that its word is sampled at the next edge.
    state_next.take = state_next.ready & div_take_next;

    // Lanes only move while streaming.
    if (run) begin
      for (int i = 0; i < gdts_pkg::LANES; i++) begin
        step = gdts_shift_step(state_reg.bufs[i], word_i[i] & word_mask, div_fill, div_take, ratio_one);
        state_next.bufs[i] = step[gdts_pkg::BUF_W+1:2];
        state_next.lanes[i].rise = step[0];
        state_next.lanes[i].fall = step[1];
      end

      if (ratio_one) begin
        // One-to-one sends a plain clock.
        state_next.clk_buf = '0;
        state_next.clk_pair.rise = gdts_pkg::CLK_RISE_1TO1;
        state_next.clk_pair.fall = gdts_pkg::CLK_FALL_1TO1;
      end else begin
        step = gdts_shift_step(state_reg.clk_buf, clk_pattern, div_fill, div_take, 1'b0);
        state_next.clk_buf = step[gdts_pkg::BUF_W+1:2];
        state_next.clk_pair.rise = step[0];
        state_next.clk_pair.fall = step[1];
      end
    end else begin
      // Idle lanes sit low and empty so the first word starts at bit zero.
      state_next.bufs = '0;
      state_next.clk_buf = '0;
      state_next.lanes = '0;
      state_next.clk_pair = '0;
    end
  end

  // ----------------------------------------------------------------------------
  // Register everything
  // ----------------------------------------------------------------------------
  // Asynchronous reset clears the whole record.
  // outputs from dedicated clock
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output is a flip-flop of the state record.
  assign lane_o = state_reg.lanes;
  assign clk_lane_o = state_reg.clk_pair;
  assign word_take_o = state_reg.take;
  assign edge_stop_o = state_reg.stop;
  assign sync_reset_o = state_reg.sreset;
  assign clk_shift_en_o = state_reg.shift_en;
  assign ready_o = state_reg.ready;

endmodule : gdts_serializer_top
`default_nettype wire

// ===== verification/gdts_serializer_top_props.sv
// Concurrent checks on the ports of the geared DDR transmit serializer.
`timescale 1ns/10ps
`default_nettype none
module gdts_serializer_top_props (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire gdts_pkg::gdts_cfg_s cfg_i,
  input wire logic lock_i,
  input wire gdts_pkg::gdts_word_t [gdts_pkg::LANES-1:0] word_i,
  input wire gdts_pkg::gdts_pair_s [gdts_pkg::LANES-1:0] lane_o,
  input wire gdts_pkg::gdts_pair_s clk_lane_o,
  input wire logic word_take_o,
  input wire logic edge_stop_o,
  input wire logic sync_reset_o,
  input wire logic clk_shift_en_o,
  input wire logic ready_o
);
  // -----------------------------------------------------------------------------
  // Mode decode and defaults
  // -----------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire m4 = (cfg_i.mode == gdts_pkg::MODE_4TO1); // Four-to-one gearing selected.
  wire m7 = (cfg_i.mode == gdts_pkg::MODE_7TO1); // Seven-to-one gearing selected.
  wire m1 = (cfg_i.mode == gdts_pkg::MODE_1TO1); // Plain one-to-one gearing selected.

  // -----------------------------------------------------------------------------
  // Properties
  // -----------------------------------------------------------------------------
  property p_stop_gate; edge_stop_o |-> cfg_i.stop_en; endproperty
  a_stop_gate: assert property (p_stop_gate) else $error("edge stop raised with stop disabled");
  // The lock guard keeps a restart in mid-sequence from counting as a short phase.
  property p_reset_len; $rose(sync_reset_o) ##0 lock_i[*4] |-> sync_reset_o ##1 !sync_reset_o; endproperty
  a_reset_len: assert property (p_reset_len) else $error("reset phase length wrong");
  property p_ready_after; $fell(sync_reset_o) ##0 lock_i[*4] |=> ready_o; endproperty
  a_ready_after: assert property (p_ready_after) else $error("ready late after reset phase");
  property p_take_4to1; m4 && word_take_o |=> !word_take_o ##1 (word_take_o || !ready_o); endproperty
  a_take_4to1: assert property (p_take_4to1) else $error("four-to-one word pacing wrong");
  property p_take_1to1; m1 && ready_o |-> word_take_o; endproperty
  a_take_1to1: assert property (p_take_1to1) else $error("one-to-one take not constant");
  property p_clk_7to1; m7 && word_take_o |=> !ready_o || (clk_lane_o.rise && clk_lane_o.fall); endproperty
  a_clk_7to1: assert property (p_clk_7to1) else $error("forwarded clock not aligned to word");
  property p_data_lsb;
    m4 && word_take_o |=> !ready_o || (lane_o[3].rise == $past(word_i[3][0]) && lane_o[3].fall == $past(word_i[3][1]));
  endproperty
  a_data_lsb: assert property (p_data_lsb) else $error("first bit pair not lsb first");
  property p_shift_en; (cfg_i.centred && m4) ##1 $stable(cfg_i) |-> clk_shift_en_o; endproperty
  a_shift_en: assert property (p_shift_en) else $error("shifted clock not requested");

  // Main scenarios seen.
  c_ready: cover property ($rose(ready_o));
  c_take7: cover property (m7 && word_take_o);
  c_shift: cover property (clk_shift_en_o);
endmodule // gdts_serializer_top_props

bind gdts_serializer_top gdts_serializer_top_props gdts_serializer_top_props_i (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cfg_i(cfg_i), .lock_i(lock_i), .word_i(word_i),
  .lane_o(lane_o), .clk_lane_o(clk_lane_o), .word_take_o(word_take_o), .edge_stop_o(edge_stop_o),
  .sync_reset_o(sync_reset_o), .clk_shift_en_o(clk_shift_en_o), .ready_o(ready_o));
`default_nettype wire

// ===== verification/gdts_rx_model.sv
// Behavioural serial receiver that rebuilds parallel words from the lane and clock pairs.
`timescale 1ns/10ps
`default_nettype none
module gdts_rx_model (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic ready_i,
  input wire logic [gdts_pkg::CNT_W-1:0] nbits_i,
  input wire gdts_pkg::gdts_pair_s [gdts_pkg::LANES-1:0] lane_i,
  input wire gdts_pkg::gdts_pair_s clk_lane_i,
  output var gdts_pkg::gdts_word_t [gdts_pkg::LANES:0] word_o,
  output var logic word_valid_o
);
  gdts_pkg::gdts_pair_s [gdts_pkg::LANES:0] all_v; // Top entry is the forwarded clock lane.
  gdts_pkg::gdts_word_t [gdts_pkg::LANES:0] acc; // Words under assembly.
  logic ready_q; // Ready seen one edge earlier.
  int cnt; // Bits gathered of the current word.
  assign all_v = {clk_lane_i, lane_i};

  // Framing starts one cycle after ready, when the first taken word reaches the pins.
  // Real receivers align on the clock pattern instead; this shortcut keeps the model small.
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_q <= 1'b0;
      word_valid_o <= 1'b0;
      word_o <= '0;
      acc = '0;
      cnt = 0;
    end else begin
      word_valid_o <= 1'b0;
      if (ready_q && ready_i) begin
        // Rising-edge bit precedes the falling-edge bit in time.
        for (int b = 0; b < 2; b++) begin
          for (int l = 0; l <= gdts_pkg::LANES; l++) begin
            acc[l][cnt] = (b == 0) ? all_v[l].rise : all_v[l].fall;
          end
          cnt++;
          if (cnt == int'(nbits_i)) begin
            word_o <= acc;
            word_valid_o <= 1'b1;
            acc = '0;
            cnt = 0;
          end
        end
      end
      ready_q <= ready_i;
    end
  end
endmodule // gdts_rx_model
`default_nettype wire

// ===== verification/geared_ddr_tx_serializer_tb.sv
// Self-checking testbench of the geared DDR transmit serializer with a receiver model.
`timescale 1ns/10ps
`default_nettype none
module geared_ddr_tx_serializer_tb;
  logic core_clk_i;
  logic reset_n_i;
  gdts_pkg::gdts_cfg_s cfg_i;
  logic lock_i;
  gdts_pkg::gdts_word_t [gdts_pkg::LANES-1:0] word_i;
  gdts_pkg::gdts_pair_s [gdts_pkg::LANES-1:0] lane_o;
  gdts_pkg::gdts_pair_s clk_lane_o;
  logic word_take_o, edge_stop_o, sync_reset_o, clk_shift_en_o, ready_o;
  logic [gdts_pkg::CNT_W-1:0] rx_nbits; // Word length the receiver frames.
  gdts_pkg::gdts_word_t [gdts_pkg::LANES:0] rx_word, e_mon;
  logic rx_valid;
  gdts_pkg::gdts_word_t [gdts_pkg::LANES:0] exp_q[$]; // Words expected at the receiver.
  int fail_count = 0;
  int num_checks = 0;

  gdts_serializer_top gdts_serializer_top_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cfg_i(cfg_i),
    .lock_i(lock_i), .word_i(word_i), .lane_o(lane_o), .clk_lane_o(clk_lane_o), .word_take_o(word_take_o),
    .edge_stop_o(edge_stop_o), .sync_reset_o(sync_reset_o), .clk_shift_en_o(clk_shift_en_o), .ready_o(ready_o));
  gdts_rx_model gdts_rx_model_i (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ready_i(ready_o),
    .nbits_i(rx_nbits), .lane_i(lane_o), .clk_lane_i(clk_lane_o), .word_o(rx_word), .word_valid_o(rx_valid));

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // -----------------------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------------------
  task automatic tick;
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic check1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check7(input string what, input logic [6:0] exp, input logic [6:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Resets everything, then raises lock just after an edge so startup counts from the next edge.
  task automatic start_up(input gdts_pkg::gdts_cfg_s c, input logic [gdts_pkg::CNT_W-1:0] nb);
    reset_n_i = 1'b0;
    lock_i = 1'b0;
    cfg_i = c;
    rx_nbits = nb;
    exp_q.delete();
    repeat (2) tick;
    reset_n_i = 1'b1;
    repeat (2) tick;
    lock_i = 1'b1;
  endtask
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Each word framed while the queue is not empty is matched against the oldest word handed to the design.
  always @(negedge core_clk_i) begin
    if (rx_valid === 1'b1 && exp_q.size() > 0) begin
      e_mon = exp_q.pop_front();
      for (int l = 0; l <= gdts_pkg::LANES; l++) check7("rx word", e_mon[l], rx_word[l]);
    end
  end

  // -----------------------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------------------
  task automatic test_startup;
    for (int s = 0; s < 2; s++) begin
      start_up('{mode: gdts_pkg::MODE_7TO1, stop_en: s[0], centred: 1'b0}, gdts_pkg::BITS_7TO1);
      for (int k = 1; k <= 14; k++) begin
        tick;
        check1("edge_stop", s[0] && k < 13, edge_stop_o);
        check1("sync_reset", k >= 5 && k <= 8, sync_reset_o);
        check1("ready", k >= 13, ready_o);
        check1("word_take", k == 13, word_take_o);
      end
    end
    $display("test_startup done");
  endtask
  // Streams words, counts the takes over fourteen cycles and lets the monitor judge the pins.
  task automatic test_stream(input gdts_pkg::gdts_mode_e m, input logic [gdts_pkg::CNT_W-1:0] nb,
                             input logic [6:0] mask, input logic [6:0] clk_exp, input logic [6:0] takes);
    gdts_pkg::gdts_word_t [gdts_pkg::LANES:0] e;
    logic [6:0] seen;
    start_up('{mode: m, stop_en: 1'b1, centred: 1'b0}, nb);
    for (int k = 0; k < 30 && ready_o !== 1'b1; k++) tick;
    seen = 7'h00;
    for (int i = 0; i < 14; i++) begin
      if (word_take_o === 1'b1) begin
        for (int l = 0; l < gdts_pkg::LANES; l++) begin
          word_i[l] = 7'h35 + 7'(seen * 29 + l * 11);
          e[l] = word_i[l] & mask;
        end
        e[gdts_pkg::LANES] = clk_exp;
        exp_q.push_back(e);
        seen++;
      end
      tick;
    end
    check7("takes", takes, seen);
    repeat (8) tick;
    check7("backlog", 7'h00, 7'(exp_q.size()));
    $display("test_stream done");
  endtask
  task automatic test_shift;
    for (int k = 0; k < 3; k++) begin
      start_up('{mode: (k == 1) ? gdts_pkg::MODE_7TO1 : gdts_pkg::MODE_4TO1, stop_en: 1'b1, centred: k != 2},
               gdts_pkg::BITS_4TO1);
      tick;
      check1("clk_shift_en", k == 0, clk_shift_en_o);
    end
    $display("test_shift done");
  endtask
  // Losing lock while streaming must stop at once and then rerun the whole startup.
  task automatic test_lock_loss;
    int k;
    start_up('{mode: gdts_pkg::MODE_4TO1, stop_en: 1'b1, centred: 1'b0}, gdts_pkg::BITS_4TO1);
    for (k = 0; k < 30 && ready_o !== 1'b1; k++) tick;
    repeat (3) tick;
    lock_i = 1'b0;
    tick;
    check1("ready after lock loss", 1'b0, ready_o);
    check1("take after lock loss", 1'b0, word_take_o);
    lock_i = 1'b1;
    for (k = 0; k < 30 && ready_o !== 1'b1; k++) tick;
    check7("relock cycles", 7'h0D, 7'(k));
    $display("test_lock_loss done");
  endtask

  initial begin
    reset_n_i = 1'b0;
    lock_i = 1'b0;
    cfg_i = '0;
    word_i = '0;
    rx_nbits = gdts_pkg::BITS_7TO1;
    repeat (20) @(posedge core_clk_i);
    #1;
    reset_n_i = 1'b1;
    test_startup;
    test_stream(gdts_pkg::MODE_7TO1, gdts_pkg::BITS_7TO1, 7'h7F, gdts_pkg::CLK_PAT_7TO1, 7'h04);
    test_stream(gdts_pkg::MODE_4TO1, gdts_pkg::BITS_4TO1, 7'h0F, gdts_pkg::CLK_PAT_4TO1, 7'h07);
    test_stream(gdts_pkg::MODE_1TO1, gdts_pkg::BITS_1TO1, 7'h01, {6'h00, gdts_pkg::CLK_FALL_1TO1}, 7'h0E);
    test_stream(gdts_pkg::gdts_mode_e'(2'h3), gdts_pkg::BITS_7TO1, 7'h7F, gdts_pkg::CLK_PAT_7TO1, 7'h04);
    test_shift;
    test_lock_loss;
    finish_test;
  end

  // The scenarios need some 260 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (3000) @(posedge core_clk_i);
    fail_count++;
    finish_test;
  end
endmodule // geared_ddr_tx_serializer_tb
`default_nettype wire
